// >>> logic/tcc_top.sv
// Timer 2 compare and capture unit behind the special function register port
`timescale 1ns/1ns
module tcc_top
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Special function register port
  input  wire tcc_sfr_req_t sfrReq,
  output logic [7:0]        sfrRdData,
  // Timer 2 count, same clock
  input  wire logic [15:0]  timer2Value,
  // Capture input pins
  input  wire logic [3:0]   captureIn,
  // Compare output port
  output logic [7:0]        compareOutPort
);

  ////////////////////////////////////////////////////////////////////////////
  // Register select, used by both the write and the read path
  function automatic logic [4:0] regSel(input logic [7:0] a);
    case (a)
      ADDR_CMP0_LO:  regSel = 5'h00;
      ADDR_CMP1_LO:  regSel = 5'h01;
      ADDR_CMP2_LO:  regSel = 5'h02;
      ADDR_CMP0_HI:  regSel = 5'h03;
      ADDR_CMP1_HI:  regSel = 5'h04;
      ADDR_CMP2_HI:  regSel = 5'h05;
      ADDR_CAP0_LO:  regSel = 5'h06;
      ADDR_CAP1_LO:  regSel = 5'h07;
      ADDR_CAP2_LO:  regSel = 5'h08;
      ADDR_CAP3_LO:  regSel = 5'h09;
      ADDR_CAP0_HI:  regSel = 5'h0a;
      ADDR_CAP1_HI:  regSel = 5'h0b;
      ADDR_CAP2_HI:  regSel = 5'h0c;
      ADDR_CAP3_HI:  regSel = 5'h0d;
      ADDR_SET_EN:   regSel = 5'h0e;
      ADDR_CLR_EN:   regSel = 5'h0f;
      ADDR_EDGE_CTL: regSel = 5'h10;
      default:       regSel = 5'h1f;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  tcc_state_t stateQ;
  tcc_state_t stateD;

  logic [CMP_PAIRS-1:0]    matchNow;
  logic [CMP_PAIRS-1:0]    matchEvent;
  logic [CAP_CHANNELS-1:0] settled;
  logic [CAP_CHANNELS-1:0] riseEvent;
  logic [CAP_CHANNELS-1:0] fallEvent;
  logic [CAP_CHANNELS-1:0] capEvent;
  logic [4:0]              sel;

  assign sel = regSel(sfrReq.addr);

  // A match acts once when equality begins; a prescaled timer may hold a
  // value for many clocks and must not toggle the port each one
  genvar gm;
  generate
    for (gm = 0; gm < CMP_PAIRS; gm++) begin : gMatch
      assign matchNow[gm]   = (timer2Value == stateQ.cmp[gm]);
      assign matchEvent[gm] = matchNow[gm] & ~stateQ.matchPrev[gm];
    end
  endgenerate

  // Edges count only once the second and third sync stages agree; the first
  // stage feeds nothing but the second
  genvar gc;
  generate
    for (gc = 0; gc < CAP_CHANNELS; gc++) begin : gCap
      assign settled[gc]   = (stateQ.sync2[gc] == stateQ.sync3[gc]);
      assign riseEvent[gc] = settled[gc] & stateQ.sync3[gc] & ~stateQ.level[gc];
      assign fallEvent[gc] = settled[gc] & ~stateQ.sync3[gc] & stateQ.level[gc];
      assign capEvent[gc]  = (riseEvent[gc] & stateQ.edgeCtl[RISE_POS[gc]])
        | (fallEvent[gc] & stateQ.edgeCtl[FALL_POS[gc]]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    stateD = stateQ;

    // Input synchronisers
    stateD.sync1 = captureIn;
    stateD.sync2 = stateQ.sync1;
    stateD.sync3 = stateQ.sync2;
    for (int i = 0; i < CAP_CHANNELS; i++) begin
      if (settled[i]) begin
        stateD.level[i] = stateQ.sync3[i];
      end
    end
    stateD.matchPrev = matchNow;

    // Software writes
    if (sfrReq.wr) begin
      case (sel)
        5'h00:   stateD.cmp[0][7:0]  = sfrReq.wrData;
        5'h01:   stateD.cmp[1][7:0]  = sfrReq.wrData;
        5'h02:   stateD.cmp[2][7:0]  = sfrReq.wrData;
        5'h03:   stateD.cmp[0][15:8] = sfrReq.wrData;
        5'h04:   stateD.cmp[1][15:8] = sfrReq.wrData;
        5'h05:   stateD.cmp[2][15:8] = sfrReq.wrData;
        5'h06:   stateD.cap[0][7:0]  = sfrReq.wrData;
        5'h07:   stateD.cap[1][7:0]  = sfrReq.wrData;
        5'h08:   stateD.cap[2][7:0]  = sfrReq.wrData;
        5'h09:   stateD.cap[3][7:0]  = sfrReq.wrData;
        5'h0a:   stateD.cap[0][15:8] = sfrReq.wrData;
        5'h0b:   stateD.cap[1][15:8] = sfrReq.wrData;
        5'h0c:   stateD.cap[2][15:8] = sfrReq.wrData;
        5'h0d:   stateD.cap[3][15:8] = sfrReq.wrData;
        5'h0e:   stateD.setEn        = sfrReq.wrData;
        5'h0f:   stateD.clrEn        = sfrReq.wrData;
        5'h10:   stateD.edgeCtl      = sfrReq.wrData;
        default: stateD.setEn        = stateQ.setEn;
      endcase
    end

    // A capture in the same cycle as a software write wins, so no edge is lost
    for (int i = 0; i < CAP_CHANNELS; i++) begin
      if (capEvent[i]) begin
        stateD.cap[i][7:0]  = timer2Value[7:0];
        stateD.cap[i][15:8] = timer2Value[15:8];
      end
    end

    // Compare actions; a clear on the same cycle as a set wins
    for (int b = SET_CLR_LSB; b <= SET_CLR_MSB; b++) begin
      if (matchEvent[0] && stateQ.setEn[b]) begin
        stateD.port[b] = 1'b1;
      end
      if (matchEvent[1] && stateQ.clrEn[b]) begin
        stateD.port[b] = 1'b0;
      end
    end
    if (matchEvent[2] && stateQ.clrEn[TOGGLE_BIT6]) begin
      stateD.port[TOGGLE_BIT6] = ~stateQ.port[TOGGLE_BIT6];
    end
    if (matchEvent[2] && stateQ.clrEn[TOGGLE_BIT7]) begin
      stateD.port[TOGGLE_BIT7] = ~stateQ.port[TOGGLE_BIT7];
    end

    // Read data, one clock after the strobe; unmapped addresses read zero
    if (sfrReq.rd) begin
      case (sel)
        5'h00:   stateD.rdData = stateQ.cmp[0][7:0];
        5'h01:   stateD.rdData = stateQ.cmp[1][7:0];
        5'h02:   stateD.rdData = stateQ.cmp[2][7:0];
        5'h03:   stateD.rdData = stateQ.cmp[0][15:8];
        5'h04:   stateD.rdData = stateQ.cmp[1][15:8];
        5'h05:   stateD.rdData = stateQ.cmp[2][15:8];
        5'h06:   stateD.rdData = stateQ.cap[0][7:0];
        5'h07:   stateD.rdData = stateQ.cap[1][7:0];
        5'h08:   stateD.rdData = stateQ.cap[2][7:0];
        5'h09:   stateD.rdData = stateQ.cap[3][7:0];
        5'h0a:   stateD.rdData = stateQ.cap[0][15:8];
        5'h0b:   stateD.rdData = stateQ.cap[1][15:8];
        5'h0c:   stateD.rdData = stateQ.cap[2][15:8];
        5'h0d:   stateD.rdData = stateQ.cap[3][15:8];
        5'h0e:   stateD.rdData = stateQ.setEn;
        5'h0f:   stateD.rdData = stateQ.clrEn;
        5'h10:   stateD.rdData = stateQ.edgeCtl;
        default: stateD.rdData = RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateQ           <= '0;
      stateQ.cmp       <= {CMP_PAIRS{RST_WORD}};
      stateQ.cap       <= {CAP_CHANNELS{RST_WORD}};
      stateQ.setEn     <= RST_BYTE;
      stateQ.clrEn     <= RST_BYTE;
      stateQ.edgeCtl   <= RST_BYTE;
      stateQ.port      <= RST_PORT;
      stateQ.rdData    <= RST_BYTE;
      // Start high so a timer at zero right after reset does not fire
      stateQ.matchPrev <= {CMP_PAIRS{1'b1}};
    end else begin
      stateQ <= stateD;
    end
  end

  assign sfrRdData      = stateQ.rdData;
  assign compareOutPort = stateQ.port;

endmodule

// >>> pkg/tcc_pkg.sv
// Package for the timer compare and capture unit: register map, layouts, reset values
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_CMP0_LO  = 8'ha9;
  localparam logic [7:0] ADDR_CMP1_LO  = 8'haa;
  localparam logic [7:0] ADDR_CMP2_LO  = 8'hab;
  localparam logic [7:0] ADDR_CAP0_LO  = 8'hac;
  localparam logic [7:0] ADDR_CAP1_LO  = 8'had;
  localparam logic [7:0] ADDR_CAP2_LO  = 8'hae;
  localparam logic [7:0] ADDR_CAP3_LO  = 8'haf;
  localparam logic [7:0] ADDR_CMP0_HI  = 8'ha3;
  localparam logic [7:0] ADDR_CMP1_HI  = 8'ha4;
  localparam logic [7:0] ADDR_CMP2_HI  = 8'ha5;
  localparam logic [7:0] ADDR_SET_EN   = 8'ha6;
  localparam logic [7:0] ADDR_CLR_EN   = 8'ha7;
  localparam logic [7:0] ADDR_EDGE_CTL = 8'h9a;
  localparam logic [7:0] ADDR_CAP0_HI  = 8'h9b;
  localparam logic [7:0] ADDR_CAP1_HI  = 8'h9c;
  localparam logic [7:0] ADDR_CAP2_HI  = 8'h9d;
  localparam logic [7:0] ADDR_CAP3_HI  = 8'h9e;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SET_CLR_LSB   = 0;
  localparam int SET_CLR_MSB   = 5;
  localparam int TOGGLE_BIT6   = 6;
  localparam int TOGGLE_BIT7   = 7;
  localparam int CAP_CHANNELS  = 4;
  localparam int CMP_PAIRS     = 3;

  // Rise and fall enable positions per channel in the edge control register
  localparam logic [3:0][2:0] RISE_POS = {3'h6, 3'h4, 3'h2, 3'h0};
  localparam logic [3:0][2:0] FALL_POS = {3'h7, 3'h5, 3'h3, 3'h1};

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_PORT = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } tcc_sfr_req_t;

  typedef struct packed {
    logic [CMP_PAIRS-1:0][15:0]    cmp;
    logic [CAP_CHANNELS-1:0][15:0] cap;
    logic [7:0]                    setEn;
    logic [7:0]                    clrEn;
    logic [7:0]                    edgeCtl;
    logic [7:0]                    port;
    logic [CMP_PAIRS-1:0]          matchPrev;
    logic [CAP_CHANNELS-1:0]       sync1;
    logic [CAP_CHANNELS-1:0]       sync2;
    logic [CAP_CHANNELS-1:0]       sync3;
    logic [CAP_CHANNELS-1:0]       level;
    logic [7:0]                    rdData;
  } tcc_state_t;

endpackage

// >>> tb/tcc_top_monitor.sv
// Checker on the compare outputs and register reads of the unit
`timescale 1ns/1ns
module tcc_monitor
  import tcc_pkg::*;
(
  // Clock and reset
  input logic         mclk,
  input logic         rst_n,
  // Register port
  input tcc_sfr_req_t sfrReq,
  input logic [7:0]   sfrRdData,
  // Timer and pins
  input logic [15:0]  timer2Value,
  input logic [3:0]   captureIn,
  input logic [7:0]   compareOutPort
);
  logic [7:0] shadow_q [256];
  logic [2:0] eq_q;
  logic [2:0] eq;
  logic [2:0] hit;
  logic [7:0] setEn;
  logic [7:0] clrEn;
  assign setEn = shadow_q[ADDR_SET_EN];
  assign clrEn = shadow_q[ADDR_CLR_EN];
  assign eq[0] = timer2Value == {shadow_q[ADDR_CMP0_HI], shadow_q[ADDR_CMP0_LO]};
  assign eq[1] = timer2Value == {shadow_q[ADDR_CMP1_HI], shadow_q[ADDR_CMP1_LO]};
  assign eq[2] = timer2Value == {shadow_q[ADDR_CMP2_HI], shadow_q[ADDR_CMP2_LO]};
  // Only the entry into equality acts, so held equality fires once
  assign hit = eq & ~eq_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shadow_q <= '{default: 8'h00};
      eq_q     <= 3'h7;
    end else begin
      eq_q <= eq;
      if (sfrReq.wr) shadow_q[sfrReq.addr] <= sfrReq.wrData;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_SET: assert property (hit[0] && !hit[1] |=>
    (compareOutPort[5:0] & $past(setEn[5:0])) == $past(setEn[5:0])) else $error("set missed");
  AST_CLR: assert property (hit[1] |=>
    (compareOutPort[5:0] & $past(clrEn[5:0])) == 6'h00) else $error("clear missed");
  AST_TOG6: assert property (hit[2] |=>
    compareOutPort[6] == ($past(compareOutPort[6]) ^ $past(clrEn[6]))) else $error("bit 6");
  AST_TOG7: assert property (hit[2] |=>
    compareOutPort[7] == ($past(compareOutPort[7]) ^ $past(clrEn[7]))) else $error("bit 7");
  AST_HOLD: assert property (hit == 3'h0 |=> $stable(compareOutPort))
    else $error("port moved without match");
  AST_RD: assert property (sfrReq.rd && sfrReq.addr == ADDR_CLR_EN |=>
    sfrRdData == $past(clrEn)) else $error("read data wrong");
  AST_UNMAP: assert property (sfrReq.rd && sfrReq.addr == 8'h00 |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_RDHOLD: assert property (!sfrReq.rd |=> $stable(sfrRdData)) else $error("read data moved");
  cover property (hit[0] && hit[1]);
  cover property (hit[2]);
  cover property (sfrReq.rd && sfrReq.addr == ADDR_CLR_EN);
  cover property (captureIn != 4'h0);
endmodule
bind tcc_top tcc_monitor MON (
  .mclk(mclk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
  .timer2Value(timer2Value), .captureIn(captureIn), .compareOutPort(compareOutPort));

// >>> tb/tcc_pins.sv
// Model of the four capture pins driven from outside
`timescale 1ns/1ns
module tcc_pins (
  // Clock
  input  logic       mclk,
  // Capture pins
  output logic [3:0] captureIn
);
  initial captureIn = 4'h0;
  // Each level stands four cycles; shorter pulses may be lost in the synchroniser
  task automatic drive(input int ch, input logic lvl);
    @(posedge mclk);
    captureIn[ch] <= lvl;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// >>> tb/tcc_top_tb.sv
// Self-checking bench for the compare and capture unit
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module tcc_top_tb
  import tcc_pkg::*;
;
  logic         mclk        = 1'b0;
  logic         rst_n       = 1'b0;
  tcc_sfr_req_t sfrReq      = '0;
  logic [15:0]  timer2Value = 16'h0000;
  logic [7:0]   sfrRdData;
  logic [3:0]   captureIn;
  logic [7:0]   compareOutPort;
  int           num_errors  = 0;
  int           comparisons = 0;
  int           cycles      = 0;
  always #5 mclk = ~mclk;
  tcc_top DUT (.mclk(mclk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .timer2Value(timer2Value), .captureIn(captureIn), .compareOutPort(compareOutPort));
  tcc_pins PINS (.mclk(mclk), .captureIn(captureIn));
  ////////////////////////////////////////////////////////////
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    sfrReq <= '0;
  endtask
  task automatic chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    @(posedge mclk);
    sfrReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    sfrReq <= '0;
    #1;
    `CHK(nm, ex, sfrRdData)
  endtask
  task automatic tick(input logic [15:0] v, input int n);
    @(posedge mclk);
    timer2Value <= v;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Mapped addresses: 0xa9..0xaf, 0xa3..0xa7, 0x9a..0x9e
  function automatic logic [7:0] ad(input int k);
    return k < 7 ? 8'ha9 + 8'(k) : k < 12 ? 8'h9c + 8'(k) : 8'h8e + 8'(k);
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int k = 0; k < 17; k++) chk("reset value", ad(k), 8'h00);
    for (int k = 0; k < 17; k++) wrReg(ad(k), ad(k) ^ 8'h5a);
    for (int k = 0; k < 17; k++) chk("readback", ad(k), ad(k) ^ 8'h5a);
    wrReg(8'h00, 8'hff);
    chk("unmapped", 8'h00, 8'h00);
  endtask
  task automatic t_cmp();
    wrReg(ADDR_CMP0_HI, 8'h12);
    wrReg(ADDR_CMP0_LO, 8'h34);
    wrReg(ADDR_CMP1_HI, 8'h12);
    wrReg(ADDR_CMP1_LO, 8'h35);
    wrReg(ADDR_CMP2_HI, 8'h12);
    wrReg(ADDR_CMP2_LO, 8'h36);
    wrReg(ADDR_SET_EN, 8'hff);
    wrReg(ADDR_CLR_EN, 8'hd5);
    tick(16'h1234, 4);
    `CHK("set port", 8'h3f, compareOutPort)
    tick(16'h1235, 2);
    `CHK("clear port", 8'h2a, compareOutPort)
    // Held equality must toggle only once
    tick(16'h1236, 4);
    `CHK("toggle both", 8'hea, compareOutPort)
    wrReg(ADDR_CLR_EN, 8'h55);
    tick(16'h0000, 2);
    tick(16'h1236, 2);
    `CHK("toggle one", 8'haa, compareOutPort)
    wrReg(ADDR_CMP1_LO, 8'h34);
    tick(16'h0000, 2);
    tick(16'h1234, 2);
    `CHK("clear wins", 8'haa, compareOutPort)
  endtask
  task automatic t_cap();
    logic [15:0] exp;
    logic [15:0] t;
    for (int ch = 0; ch < 4; ch++) begin
      wrReg(8'(ADDR_CAP0_LO + ch), 8'h00);
      wrReg(8'(ADDR_CAP0_HI + ch), 8'h00);
      exp = 16'h0000;
      for (int m = 1; m < 4; m++) begin
        wrReg(ADDR_EDGE_CTL, 8'(m << (2 * ch)));
        for (int e = 0; e < 2; e++) begin
          t = 16'(ch * 4099 + m * 257 + e * 17 + 1);
          tick(t, 0);
          PINS.drive(ch, e == 0);
          if (m[e]) exp = t;
          chk("capture low", 8'(ADDR_CAP0_LO + ch), exp[7:0]);
          chk("capture high", 8'(ADDR_CAP0_HI + ch), exp[15:8]);
        end
      end
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("Errors %0d in %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run needs about 450 cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_cmp();
    t_cap();
    results();
  end
endmodule
